/* tmr2_pkg.sv */
package tmr2_pkg;

  // ==========================================
  // Register map
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h70;
  localparam logic [7:0] ADDR_ASYNC_STATUS = 8'hb6;
  localparam logic [7:0] ADDR_CONTROL_A = 8'hb0;
  localparam logic [7:0] ADDR_CONTROL_B = 8'hb1;
  localparam logic [7:0] ADDR_COUNT = 8'hb2;
  localparam logic [7:0] ADDR_COMPARE_A = 8'hb3;
  localparam logic [7:0] ADDR_COMPARE_B = 8'hb4;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h37;

  // ==========================================
  // Field positions and reset values
  localparam int CTLB_FORCE_A = 7;
  localparam int CTLB_FORCE_B = 6;
  localparam int CTLB_WAVE_UPPER = 3;
  localparam int CTLA_COM_A = 6;
  localparam int CTLA_COM_B = 4;
  localparam int STAT_EXT_CLOCK = 6;
  localparam int STAT_ASYNC_SEL = 5;
  localparam int BUSY_COUNT = 4;
  localparam int BUSY_COMPARE_A = 3;
  localparam int BUSY_COMPARE_B = 2;
  localparam int BUSY_CONTROL_A = 1;
  localparam int BUSY_CONTROL_B = 0;
  localparam int IRQ_MATCH_B = 2;
  localparam int IRQ_MATCH_A = 1;
  localparam int IRQ_OVERFLOW = 0;
  localparam logic [7:0] CTLA_WRITE_MASK = 8'hf3;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam int PRESCALE_BITS = 10;

  // Lower waveform mode bits
  localparam logic [1:0] WAVE_NORMAL = 2'h0;
  localparam logic [1:0] WAVE_PHASE = 2'h1;
  localparam logic [1:0] WAVE_CTC = 2'h2;
  localparam logic [1:0] WAVE_FAST = 2'h3;

  typedef enum logic {TMR2_DIR_UP, TMR2_DIR_DOWN} tmr2_dir_e;

  // ==========================================
  // Helpers
  function automatic logic is_pwm(input logic [2:0] mode);
    return mode[1:0] == WAVE_PHASE || mode[1:0] == WAVE_FAST;
  endfunction

  function automatic logic top_is_compare_a(input logic [2:0] mode);
    return mode == 3'h2 || mode == 3'h5 || mode == 3'h7;
  endfunction

  // Prescaler tap mask: tick when the masked bits are all ones
  function automatic logic [PRESCALE_BITS-1:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'h2: return 10'h007;
      3'h3: return 10'h01f;
      3'h4: return 10'h03f;
      3'h5: return 10'h07f;
      3'h6: return 10'h0ff;
      3'h7: return 10'h3ff;
      default: return 10'h000;
    endcase
  endfunction

  // Non-PWM compare action: none, toggle, clear, set
  function automatic logic match_action(input logic cur, input logic [1:0] com);
    case (com)
      2'h1: return ~cur;
      2'h2: return 1'b0;
      2'h3: return 1'b1;
      default: return cur;
    endcase
  endfunction

  function automatic logic pwm_match(input logic cur, input logic [1:0] com, input logic up, input logic tog);
    if (com[1]) begin
      return up ? com[0] : ~com[0];
    end
    return (com[0] && tog) ? ~cur : cur;
  endfunction

  // Live copy of a buffered register
  function automatic logic [7:0] live_next(input logic [7:0] cur, input logic [7:0] temp, input logic [7:0] wdata,
                                           input logic async, input logic pend, input logic wr);
    if (async) begin
      return pend ? temp : cur;
    end
    return wr ? wdata : cur;
  endfunction

endpackage

/* tmr2_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module tmr2_pin_sync (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clock_enable,
  // Pin
  input wire logic i_pin,
  // Rising edge, one cycle
  output logic o_rise
);

  logic [2:0] stages;
  logic [2:0] next_stages;

  always_comb begin
    next_stages = {stages[1:0], i_pin};
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      stages <= 3'h0;
    end else if (i_clock_enable) begin
      stages <= next_stages;
    end
  end

  // Stage zero is left to settle; only later stages are compared
  assign o_rise = stages[1] & ~stages[2];

endmodule

`default_nettype wire

/* tmr2_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module tmr2_prescaler
  import tmr2_pkg::*;
#(
  parameter int WIDTH = PRESCALE_BITS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clock_enable,
  // Source and select
  input wire logic i_src_tick,
  input wire logic [2:0] i_select,
  // Counting tick
  output logic o_tick
);

  if (WIDTH < PRESCALE_BITS) begin : g_width_check
    $error("prescaler width too small for divide by 1024");
  end

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic [PRESCALE_BITS-1:0] mask;

  always_comb begin
    next_count = i_src_tick ? WIDTH'(count + 1'b1) : count;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= '0;
    end else if (i_clock_enable) begin
      count <= next_count;
    end
  end

  assign mask = div_mask(i_select);
  assign o_tick = i_src_tick && (i_select != 3'h0) && ((count[PRESCALE_BITS-1:0] & mask) == mask);

endmodule

`default_nettype wire

/* tmr2_async_timer.sv */
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Summary of operation
// - Force bit applies match in non-PWM
// - Forced match sets no flag, no clear
// - Force bits are strobes, read zero
// - Clock select: stop, /1 .. /1024
// - Control B bits 5:4 read zero
// - Counter read/write; write blocks next match
// - Both compare values compared with counter
// - External clock buffer versus crystal enable
// - Async select picks oscillator clock
// - Async writes to counter, compare and control set busy until transfer
// - Counter, status, mask and flags read live; control and compare read temporary
// - Match request needs enable, global, flag
// - Overflow request gated; mask bits 2:0
// - Mode decode from three wave bits
// - Flags set by events, cleared by ack/one
module tmr2_async_timer
  import tmr2_pkg::*;
#(
  parameter int PRESCALE_WIDTH = PRESCALE_BITS
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_clock_enable,
  // Register port
  input wire logic [7:0] i_address,
  input wire logic [7:0] i_write_data,
  input wire logic i_write_strobe,
  input wire logic i_read_strobe,
  output logic [7:0] o_read_data,
  // Processor side
  input wire logic i_global_irq_enable,
  input wire logic i_vector_ack_match_a,
  input wire logic i_vector_ack_match_b,
  input wire logic i_vector_ack_overflow,
  output logic o_irq_match_a,
  output logic o_irq_match_b,
  output logic o_irq_overflow,
  // Oscillator and waveform pins
  input wire logic i_oscillator_pin_one,
  output logic o_ext_clock_buffer_enable,
  output logic o_crystal_osc_enable,
  output logic o_wave_out_a,
  output logic o_wave_out_b
);

  logic wr_ctla, wr_ctlb, wr_count, wr_cmpa, wr_cmpb, wr_status, wr_mask, wr_flags;
  logic osc_rise, src_tick, tick, transfer, pwm, force_a, force_b, load_count;
  logic match_a, match_b, ovf;
  logic [2:0] mode;
  logic [7:0] top, load_value;
  logic [1:0] com_a, com_b;
  logic [2:0] clr_flags, set_flags;

  logic [7:0] temp_ctla, temp_cmpa, temp_cmpb, temp_count, ctla, cmpa, cmpb;
  logic [7:0] next_temp_ctla, next_temp_cmpa, next_temp_cmpb, next_temp_count;
  logic [7:0] next_ctla, next_cmpa, next_cmpb, ctlb_wide;
  logic [3:0] temp_ctlb, ctlb, next_temp_ctlb, next_ctlb;
  logic ext_clk, async_sel, next_ext_clk, next_async_sel;
  logic [4:0] busy, next_busy;
  logic [2:0] irq_mask, next_irq_mask;

  logic [7:0] count, next_count;
  tmr2_dir_e dir, next_dir;
  logic block, next_block, wave_a, wave_b, next_wave_a, next_wave_b;
  logic [2:0] flags, next_flags;

  logic [7:0] next_read_data;
  logic next_irq_a, next_irq_b, next_irq_ovf, next_ext_buf, next_xtal;

  // ==========================================
  // Decode and clocking
  assign wr_ctla = i_write_strobe && i_address == ADDR_CONTROL_A;
  assign wr_ctlb = i_write_strobe && i_address == ADDR_CONTROL_B;
  assign wr_count = i_write_strobe && i_address == ADDR_COUNT;
  assign wr_cmpa = i_write_strobe && i_address == ADDR_COMPARE_A;
  assign wr_cmpb = i_write_strobe && i_address == ADDR_COMPARE_B;
  assign wr_status = i_write_strobe && i_address == ADDR_ASYNC_STATUS;
  assign wr_mask = i_write_strobe && i_address == ADDR_IRQ_MASK;
  assign wr_flags = i_write_strobe && i_address == ADDR_IRQ_FLAGS;

  tmr2_pin_sync u_osc_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clock_enable(i_clock_enable),
    .i_pin(i_oscillator_pin_one),
    .o_rise(osc_rise)
  );

  assign src_tick = async_sel ? osc_rise : 1'b1;
  assign transfer = async_sel & osc_rise;

  tmr2_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_prescaler (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_clock_enable(i_clock_enable),
    .i_src_tick(src_tick),
    .i_select(ctlb[2:0]),
    .o_tick(tick)
  );

  assign mode = {ctlb[CTLB_WAVE_UPPER], ctla[1:0]};
  assign pwm = is_pwm(mode);
  assign top = top_is_compare_a(mode) ? cmpa : COUNT_MAX;
  assign com_a = ctla[CTLA_COM_A+:2];
  assign com_b = ctla[CTLA_COM_B+:2];
  assign force_a = wr_ctlb && i_write_data[CTLB_FORCE_A] && !pwm;
  assign force_b = wr_ctlb && i_write_data[CTLB_FORCE_B] && !pwm;

  // ==========================================
  // Register file and temporary storage
  always_comb begin
    next_temp_ctlb = wr_ctlb ? i_write_data[3:0] : temp_ctlb;
    next_temp_ctla = wr_ctla ? (i_write_data & CTLA_WRITE_MASK) : temp_ctla;
    next_temp_cmpa = wr_cmpa ? i_write_data : temp_cmpa;
    next_temp_cmpb = wr_cmpb ? i_write_data : temp_cmpb;
    next_temp_count = wr_count ? i_write_data : temp_count;
    next_ctla = live_next(ctla, temp_ctla, i_write_data & CTLA_WRITE_MASK, async_sel,
                          transfer && busy[BUSY_CONTROL_A], wr_ctla);
    ctlb_wide = live_next({4'h0, ctlb}, {4'h0, temp_ctlb}, {4'h0, i_write_data[3:0]}, async_sel,
                          transfer && busy[BUSY_CONTROL_B], wr_ctlb);
    next_ctlb = ctlb_wide[3:0];
    next_cmpa = live_next(cmpa, temp_cmpa, i_write_data, async_sel, transfer && busy[BUSY_COMPARE_A], wr_cmpa);
    next_cmpb = live_next(cmpb, temp_cmpb, i_write_data, async_sel, transfer && busy[BUSY_COMPARE_B], wr_cmpb);
    load_count = async_sel ? (transfer && busy[BUSY_COUNT]) : wr_count;
    load_value = async_sel ? temp_count : i_write_data;
    next_busy = (busy & ~{5{transfer | ~async_sel}}) |
                ({wr_count, wr_cmpa, wr_cmpb, wr_ctla, wr_ctlb} & {5{async_sel}});
    next_ext_clk = wr_status ? i_write_data[STAT_EXT_CLOCK] : ext_clk;
    next_async_sel = wr_status ? i_write_data[STAT_ASYNC_SEL] : async_sel;
    next_irq_mask = wr_mask ? i_write_data[2:0] : irq_mask;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      temp_ctla <= REG_RESET;
      temp_ctlb <= REG_RESET[3:0];
      temp_cmpa <= REG_RESET;
      temp_cmpb <= REG_RESET;
      temp_count <= REG_RESET;
      ctla <= REG_RESET;
      ctlb <= REG_RESET[3:0];
      cmpa <= REG_RESET;
      cmpb <= REG_RESET;
      busy <= REG_RESET[4:0];
      ext_clk <= 1'b0;
      async_sel <= 1'b0;
      irq_mask <= REG_RESET[2:0];
    end else if (i_clock_enable) begin
      temp_ctla <= next_temp_ctla;
      temp_ctlb <= next_temp_ctlb;
      temp_cmpa <= next_temp_cmpa;
      temp_cmpb <= next_temp_cmpb;
      temp_count <= next_temp_count;
      ctla <= next_ctla;
      ctlb <= next_ctlb;
      cmpa <= next_cmpa;
      cmpb <= next_cmpb;
      busy <= next_busy;
      ext_clk <= next_ext_clk;
      async_sel <= next_async_sel;
      irq_mask <= next_irq_mask;
    end
  end

  // ==========================================
  // Counter, compare and waveform
  always_comb begin
    next_count = count;
    next_dir = dir;
    next_block = block;
    next_wave_a = wave_a;
    next_wave_b = wave_b;
    match_a = 1'b0;
    match_b = 1'b0;
    ovf = 1'b0;
    if (load_count) begin
      next_count = load_value;
      next_block = 1'b1;
    end else if (tick) begin
      next_block = 1'b0;
      match_a = !block && count == cmpa;
      match_b = !block && count == cmpb;
      case (mode[1:0])
        WAVE_PHASE: begin
          if (dir == TMR2_DIR_UP && count == top) begin
            next_dir = TMR2_DIR_DOWN;
            next_count = 8'(count - 8'h01);
          end else if (dir == TMR2_DIR_DOWN && count == COUNT_BOTTOM) begin
            next_dir = TMR2_DIR_UP;
            next_count = 8'(count + 8'h01);
            ovf = 1'b1;
          end else begin
            next_count = (dir == TMR2_DIR_UP) ? 8'(count + 8'h01) : 8'(count - 8'h01);
          end
        end
        WAVE_FAST: begin
          next_count = (count == top) ? COUNT_BOTTOM : 8'(count + 8'h01);
          ovf = count == top;
        end
        WAVE_CTC: begin
          next_count = (count == top) ? COUNT_BOTTOM : 8'(count + 8'h01);
          ovf = count == COUNT_MAX;
        end
        default: begin
          next_count = 8'(count + 8'h01);
          ovf = count == COUNT_MAX;
        end
      endcase
      if (!pwm) begin
        if (match_a) next_wave_a = match_action(wave_a, com_a);
        if (match_b) next_wave_b = match_action(wave_b, com_b);
      end else begin
        if (match_a) next_wave_a = pwm_match(wave_a, com_a, dir == TMR2_DIR_UP, mode[2]);
        if (match_b) next_wave_b = pwm_match(wave_b, com_b, dir == TMR2_DIR_UP, 1'b0);
        // Bottom action last, so a match at top is overridden when com bit 1 is set
        if (mode[1:0] == WAVE_FAST && count == top) begin
          if (com_a[1]) next_wave_a = ~com_a[0];
          if (com_b[1]) next_wave_b = ~com_b[0];
        end
      end
    end
    if (force_a) next_wave_a = match_action(next_wave_a, com_a);
    if (force_b) next_wave_b = match_action(next_wave_b, com_b);
    set_flags = {match_b, match_a, ovf};
    clr_flags = {i_vector_ack_match_b, i_vector_ack_match_a, i_vector_ack_overflow} |
                (wr_flags ? i_write_data[2:0] : 3'h0);
    next_flags = (flags & ~clr_flags) | set_flags;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= REG_RESET;
      dir <= TMR2_DIR_UP;
      block <= 1'b0;
      wave_a <= 1'b0;
      wave_b <= 1'b0;
      flags <= REG_RESET[2:0];
    end else if (i_clock_enable) begin
      count <= next_count;
      dir <= next_dir;
      block <= next_block;
      wave_a <= next_wave_a;
      wave_b <= next_wave_b;
      flags <= next_flags;
    end
  end

  // ==========================================
  // Outputs
  always_comb begin
    next_read_data = 8'h00;
    if (i_read_strobe) begin
      case (i_address)
        ADDR_CONTROL_A: next_read_data = temp_ctla;
        ADDR_CONTROL_B: next_read_data = {4'h0, temp_ctlb};
        ADDR_COUNT: next_read_data = count;
        ADDR_COMPARE_A: next_read_data = temp_cmpa;
        ADDR_COMPARE_B: next_read_data = temp_cmpb;
        ADDR_ASYNC_STATUS: next_read_data = {1'b0, ext_clk, async_sel, busy};
        ADDR_IRQ_MASK: next_read_data = {5'h0, irq_mask};
        ADDR_IRQ_FLAGS: next_read_data = {5'h0, flags};
        default: next_read_data = 8'h00;
      endcase
    end
    next_irq_a = irq_mask[IRQ_MATCH_A] && i_global_irq_enable && flags[IRQ_MATCH_A];
    next_irq_b = irq_mask[IRQ_MATCH_B] && i_global_irq_enable && flags[IRQ_MATCH_B];
    next_irq_ovf = irq_mask[IRQ_OVERFLOW] && i_global_irq_enable && flags[IRQ_OVERFLOW];
    next_ext_buf = ext_clk && async_sel;
    next_xtal = async_sel && !ext_clk;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_read_data <= 8'h00;
      o_irq_match_a <= 1'b0;
      o_irq_match_b <= 1'b0;
      o_irq_overflow <= 1'b0;
      o_ext_clock_buffer_enable <= 1'b0;
      o_crystal_osc_enable <= 1'b0;
      o_wave_out_a <= 1'b0;
      o_wave_out_b <= 1'b0;
    end else if (i_clock_enable) begin
      o_read_data <= next_read_data;
      o_irq_match_a <= next_irq_a;
      o_irq_match_b <= next_irq_b;
      o_irq_overflow <= next_irq_ovf;
      o_ext_clock_buffer_enable <= next_ext_buf;
      o_crystal_osc_enable <= next_xtal;
      o_wave_out_a <= next_wave_a;
      o_wave_out_b <= next_wave_b;
    end
  end

  // ==========================================
  // Assertions
  property p_force_toggles;
    @(posedge i_clock) disable iff (!i_resetn)
    (i_clock_enable && force_a && !tick && com_a == 2'h1) |=> (wave_a != $past(wave_a));
  endproperty
  a_force_toggles: assert property (p_force_toggles) else $error("forced toggle missed");

  property p_force_quiet;
    @(posedge i_clock) disable iff (!i_resetn)
    (i_clock_enable && (force_a || force_b) && !tick && !load_count) |=> (count == $past(count));
  endproperty
  a_force_quiet: assert property (p_force_quiet) else $error("force moved counter");

  property p_force_reads_zero;
    @(posedge i_clock) disable iff (!i_resetn)
    (i_clock_enable && i_read_strobe && i_address == ADDR_CONTROL_B) |=> (o_read_data[7:6] == 2'h0);
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force bits read nonzero");

  property p_reserved_zero;
    @(posedge i_clock) disable iff (!i_resetn)
    (i_clock_enable && i_read_strobe && i_address == ADDR_CONTROL_B) |=> (o_read_data[5:4] == 2'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  property p_count_load;
    @(posedge i_clock) disable iff (!i_resetn)
    (i_clock_enable && load_count) |=> (count == $past(load_value) && block);
  endproperty
  a_count_load: assert property (p_count_load) else $error("counter load lost");

  property p_busy_set;
    @(posedge i_clock) disable iff (!i_resetn)
    (i_clock_enable && async_sel && wr_cmpa) |=> busy[BUSY_COMPARE_A];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");

  property p_irq_match_a;
    @(posedge i_clock) disable iff (!i_resetn)
    i_clock_enable |=> (o_irq_match_a == $past(irq_mask[IRQ_MATCH_A] && i_global_irq_enable && flags[IRQ_MATCH_A]));
  endproperty
  a_irq_match_a: assert property (p_irq_match_a) else $error("match A request wrong");

  property p_irq_overflow;
    @(posedge i_clock) disable iff (!i_resetn)
    i_clock_enable |=> (o_irq_overflow == $past(irq_mask[IRQ_OVERFLOW] && i_global_irq_enable && flags[IRQ_OVERFLOW]));
  endproperty
  a_irq_overflow: assert property (p_irq_overflow) else $error("overflow request wrong");

  property p_clock_pins;
    @(posedge i_clock) disable iff (!i_resetn)
    !(o_ext_clock_buffer_enable && o_crystal_osc_enable);
  endproperty
  a_clock_pins: assert property (p_clock_pins) else $error("buffer and crystal both on");

  property p_flag_clear;
    @(posedge i_clock) disable iff (!i_resetn)
    (i_clock_enable && wr_flags && i_write_data[IRQ_MATCH_A] && !match_a) |=> !flags[IRQ_MATCH_A];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

endmodule

`default_nettype wire

/* tmr2_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tmr2_osc_model #(
  parameter int HALF_NS = 37
) (
  // Enable from the timer side
  input wire logic i_run,
  // Oscillator pin
  output logic o_pin
);
  // ==========================================
  // Oscillator
  // Parked low while stopped; the period is not a multiple of the system clock
  initial begin
    o_pin = 1'b0;
    forever begin
      #(HALF_NS);
      o_pin = i_run ? ~o_pin : 1'b0;
    end
  end
endmodule

`default_nettype wire

/* async_timer2_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end

module async_timer2_regs_tb;
  import tmr2_pkg::*;
  logic clk = 0, rstn = 0, ce = 1, ws = 0, rs = 0, gie = 0, ack_a = 0, ack_b = 0, ack_o = 0, osc_go = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, v, a, b;
  logic irq_a, irq_b, irq_o, ebuf, xtal, wa, wb, pin, w0;
  int n_errors = 0, num_checks = 0, cyc = 0, seed = 32'h9b07, lo, hi;
  logic [7:0] regs [7] = '{ADDR_IRQ_MASK, ADDR_ASYNC_STATUS, ADDR_CONTROL_B, ADDR_COUNT,
                           ADDR_COMPARE_A, ADDR_COMPARE_B, 8'h55};

  tmr2_async_timer dut_u (.i_clock(clk), .i_resetn(rstn), .i_clock_enable(ce), .i_address(addr),
    .i_write_data(wd), .i_write_strobe(ws), .i_read_strobe(rs), .o_read_data(rdata),
    .i_global_irq_enable(gie), .i_vector_ack_match_a(ack_a), .i_vector_ack_match_b(ack_b),
    .i_vector_ack_overflow(ack_o), .o_irq_match_a(irq_a), .o_irq_match_b(irq_b), .o_irq_overflow(irq_o),
    .i_oscillator_pin_one(pin), .o_ext_clock_buffer_enable(ebuf), .o_crystal_osc_enable(xtal),
    .o_wave_out_a(wa), .o_wave_out_b(wb));
  // The bench can pause an external source to freeze pending transfers
  tmr2_osc_model osc_u (.i_run((ebuf | xtal) & osc_go), .o_pin(pin));

  // ==========================================
  // Clock, timeout and closing
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // Register port tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad; wd <= d; ws <= 1'b1;
    @(posedge clk);
    ws <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge clk);
    addr <= ad; rs <= 1'b1;
    @(posedge clk);
    rs <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
    rd(ad, v);
    `CHK(v, e)
  endtask
  function automatic int div(input int s);
    return s < 2 ? 1 : s == 2 ? 8 : s == 3 ? 32 : s == 4 ? 64 : s == 5 ? 128 : s == 6 ? 256 : 1024;
  endfunction

  // ==========================================
  // Main sequence
  initial begin
    tick(8);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(regs[i], REG_RESET);
    for (int i = 0; i < 8; i++) begin
      a = 8'($random(seed));
      wr(ADDR_CONTROL_B, a); rchk(ADDR_CONTROL_B, a & 8'h0f);
      wr(ADDR_COMPARE_B, a); rchk(ADDR_COMPARE_B, a);
      wr(ADDR_IRQ_MASK, a); rchk(ADDR_IRQ_MASK, a & 8'h07);
    end
    // Frozen clock enable: the write must not land
    ce <= 1'b0; wr(ADDR_COMPARE_B, ~a); ce <= 1'b1; rchk(ADDR_COMPARE_B, a);
    wr(ADDR_CONTROL_B, 8'h00); wr(ADDR_COUNT, a); rchk(ADDR_COUNT, a);
    $display("test readback done");
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CONTROL_B, 8'h00); wr(ADDR_COUNT, 8'h00); wr(ADDR_CONTROL_B, 8'(s));
      tick(3 * div(s));
      wr(ADDR_CONTROL_B, 8'h00); rd(ADDR_COUNT, v);
      lo = s == 0 ? 0 : (3 * div(s) + 2) / div(s) - 1;
      hi = s == 0 ? 0 : lo + 2;
      `CHK(v >= lo && v <= hi, 1'b1)
    end
    $display("test clock select done");
    a = 8'($random(seed)); b = 8'($random(seed));
    wr(ADDR_CONTROL_A, 8'h00); wr(ADDR_COMPARE_A, a); wr(ADDR_COMPARE_B, b);
    wr(ADDR_IRQ_MASK, 8'h07); wr(ADDR_IRQ_FLAGS, 8'h07); rchk(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL_B, 8'h01); tick(300); wr(ADDR_CONTROL_B, 8'h00);
    rchk(ADDR_IRQ_FLAGS, 8'h07);
    gie <= 1'b1; tick(3); `CHK({irq_b, irq_a, irq_o}, 3'h7)
    gie <= 1'b0; tick(3); `CHK({irq_b, irq_a, irq_o}, 3'h0)
    gie <= 1'b1; wr(ADDR_IRQ_MASK, 8'h04); tick(2); `CHK({irq_b, irq_a, irq_o}, 3'h4)
    ack_b <= 1'b1; ack_o <= 1'b1; tick(1); ack_b <= 1'b0; ack_o <= 1'b0; tick(2);
    `CHK(irq_b, 1'b0)
    rchk(ADDR_IRQ_FLAGS, 8'h02);
    ack_a <= 1'b1; tick(1); ack_a <= 1'b0; rchk(ADDR_IRQ_FLAGS, 8'h00);
    $display("test flags done");
    // Stopped counter in CTC mode: toggle on A, set on B
    wr(ADDR_COMPARE_A, 8'h10); wr(ADDR_COUNT, 8'h33); wr(ADDR_CONTROL_A, 8'h72);
    tick(2); w0 = wa;
    wr(ADDR_CONTROL_B, 8'h80); tick(2); `CHK(wa, ~w0)
    wr(ADDR_CONTROL_B, 8'h40); tick(2); `CHK(wb, 1'b1)
    rchk(ADDR_IRQ_FLAGS, 8'h00);
    rchk(ADDR_COUNT, 8'h33);
    // Fast PWM to 0xff: A sets at bottom, B clears at bottom
    // force bits written as zero while in PWM
    wr(ADDR_COMPARE_B, 8'h20); wr(ADDR_CONTROL_A, 8'hb3); wr(ADDR_CONTROL_B, 8'h01);
    tick(211); wr(ADDR_CONTROL_B, 8'h00);
    rchk(ADDR_COUNT, 8'h08);
    `CHK({wa, wb}, 2'b10)
    $display("test force done");
    wr(ADDR_ASYNC_STATUS, 8'h40); wr(ADDR_ASYNC_STATUS, 8'h60); tick(2);
    `CHK({ebuf, xtal}, 2'b10)
    a = 8'($random(seed));
    wr(ADDR_COUNT, a); wr(ADDR_COMPARE_A, a); wr(ADDR_COMPARE_B, a);
    wr(ADDR_CONTROL_A, a & 8'hf0); wr(ADDR_CONTROL_B, a & 8'h0f);
    rchk(ADDR_ASYNC_STATUS, 8'h7f);
    rchk(ADDR_COMPARE_A, a);
    // Start from the busy value so a stale read cannot end the wait early
    v = 8'h7f;
    osc_go <= 1'b1;
    // no further writes until the busy bits drop
    for (int i = 0; i < 400 && v !== 8'h60; i++) rd(ADDR_ASYNC_STATUS, v);
    `CHK(v, 8'h60)
    rchk(ADDR_CONTROL_A, a & 8'hf0);
    wr(ADDR_ASYNC_STATUS, 8'h20); tick(2); `CHK({ebuf, xtal}, 2'b01)
    wr(ADDR_ASYNC_STATUS, 8'h00); tick(2); `CHK({ebuf, xtal}, 2'b00)
    wr(ADDR_COMPARE_A, 8'h00); rchk(ADDR_ASYNC_STATUS, 8'h00);
    $display("test async done");
    end_sim();
  end
endmodule

`default_nettype wire
